// file: inc/gtm_pkg.sv
package gtm_pkg;

  // Module configuration value that splits the module into two 16-bit halves.
  localparam logic [2:0] GTM_CFG_16BIT = 3'h4;

  // Half mode field encodings.
  localparam logic [1:0] GTM_MODE_ONESHOT = 2'h1;
  localparam logic [1:0] GTM_MODE_PERIODIC = 2'h2;
  localparam logic [1:0] GTM_MODE_CAPTURE = 2'h3;

  // Edge select field encodings.
  localparam logic [1:0] GTM_EDGE_RISE = 2'h0;
  localparam logic [1:0] GTM_EDGE_FALL = 2'h1;
  localparam logic [1:0] GTM_EDGE_BOTH = 2'h3;

  // Reset values and the zero count.
  localparam logic [15:0] GTM_LOAD_RST = 16'hFFFF;
  localparam logic [7:0] GTM_PRESCALE_RST = 8'h00;
  localparam logic [15:0] GTM_ZERO = 16'h0000;

  // Flag positions in the clear, mask and status vectors, and their width.
  localparam int GTM_FLAG_TIMEOUT = 0;
  localparam int GTM_FLAG_CMATCH = 1;
  localparam int GTM_FLAG_CEVENT = 2;
  localparam int GTM_FLAG_W = 3;

  typedef enum logic [2:0] {
    GTM_OP_IDLE = 3'b000,
    GTM_OP_ONESHOT = 3'b001,
    GTM_OP_PERIODIC = 3'b010,
    GTM_OP_ECOUNT = 3'b011,
    GTM_OP_ETIME = 3'b100,
    GTM_OP_PWM = 3'b101
  } gtm_op_e;

endpackage : gtm_pkg

// file: verilog/gtm_edge_detect.sv
`timescale 1ns/1ns
module gtm_edge_detect (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Pin level and edge selection.
  input wire logic pinIn,
  input wire logic [1:0] edgeSel,
  // Qualified edge, one cycle.
  output logic edgeHit
);
  import gtm_pkg::*;

  logic lastQ;
  logic lastD;

  always_comb begin
    lastD = pinIn;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      lastQ <= 1'b0;
    end else begin
      lastQ <= lastD;
    end
  end

  // Combinational so the timer sees the edge in the cycle it is detected.
  always_comb begin
    unique case (edgeSel)
      GTM_EDGE_RISE: edgeHit = pinIn && !lastQ;
      GTM_EDGE_FALL: edgeHit = !pinIn && lastQ;
      GTM_EDGE_BOTH: edgeHit = pinIn != lastQ;
      default: edgeHit = 1'b0;
    endcase
  end

endmodule : gtm_edge_detect

// file: verilog/gtm_prescaler.sv
`timescale 1ns/1ns
module gtm_prescaler #(
  parameter int PS_W = 8
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Control.
  input wire logic run,
  input wire logic reload,
  input wire logic [PS_W-1:0] prescale,
  // Tick every prescale+1 running cycles.
  output logic tick
);
  import gtm_pkg::*;

  logic [PS_W-1:0] cntQ;
  logic [PS_W-1:0] cntD;

  always_comb begin
    cntD = cntQ;
    if (reload) begin
      cntD = prescale;
    end else if (run) begin
      cntD = (cntQ == '0) ? prescale : cntQ - 1'b1; // R25
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cntQ <= GTM_PRESCALE_RST;
    end else begin
      cntQ <= cntD;
    end
  end

  assign tick = run && !reload && (cntQ == '0); // R25

endmodule : gtm_prescaler

// file: verilog/gtm_half_timer.sv
`timescale 1ns/1ns
// Operation
// R01: The half works only while the module configuration holds 0x4.
// R02: Halves A and B are two instances of this one module.
// R03: One-shot and periodic modes count down with an optional 8-bit prescaler.
// R04: Counts down from the preload and reloads load and prescale after zero.
// R05: One-shot clears its enable at time-out; periodic keeps counting.
// R06: Time-out sets a raw flag held until software clears it.
// R07: Unmasked time-out sets the masked flag and the interrupt request.
// R08: Time-out pulses the ADC trigger only when trigger enable is set.
// R09: A new load value while running is taken on the next cycle; edge count mode takes it only at the match reload.
// R10: With stall set, counting freezes while the debugger halts the processor.
// R11: The input holds each level two clocks after an edge.
// R12: No prescaler in edge count, edge time and PWM modes.
// R13: Capture mode bit 0 selects edge counting of rising, falling or both.
// R14: Software sets load minus match to the wanted edge count.
// R15: Each edge decrements by one; reaching match sets capture-match flags.
// R16: After the match the counter reloads, disables and ignores further edges.
// R17: Edge time free-runs down from load, capturing on one edge type.
// R18: Each selected edge captures the count and sets capture-event flags.
// R19: Edge time keeps counting after captures and reloads at zero.
// R20: PWM needs alternate mode 1, capture mode 0, mode field 2.
// R21: PWM counts down, reloads after zero, repeats, and raises no flags.
// R22: PWM asserts at the load value, deasserts at match, optionally inverted.
// R23: Mode field value 1 is one-shot and 2 is periodic.
// R24: Writing 1 to a clear bit clears its raw and masked flags.
// R25: Each decrement takes prescale plus one clocks.
module gtm_half_timer #(
  parameter int CNT_W = 16, // R02
  parameter int PS_W = 8
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Configuration.
  input wire logic [2:0] timerConfig,
  input wire logic [1:0] halfModeField,
  input wire logic captureModeBit,
  input wire logic alternateModeSelect,
  input wire logic [1:0] edgeSelectField,
  input wire logic adcTriggerEnable,
  input wire logic debugStallBit,
  input wire logic pwmInvertBit,
  input wire logic debugHalt,
  // Enable control; set pulse from software.
  input wire logic enableSet,
  input wire logic enableClear,
  // Values, each with a write strobe.
  input wire logic [CNT_W-1:0] intervalLoadData,
  input wire logic intervalLoadWrite,
  input wire logic [PS_W-1:0] prescaleData,
  input wire logic prescaleWrite,
  input wire logic [CNT_W-1:0] matchData,
  input wire logic matchWrite,
  // Interrupt mask and clear.
  input wire logic [gtm_pkg::GTM_FLAG_W-1:0] irqMask,
  input wire logic [gtm_pkg::GTM_FLAG_W-1:0] irqClear,
  // Capture pin.
  input wire logic capturePwmPinIn,
  // Status and results.
  output logic halfEnableBit,
  output logic [CNT_W-1:0] countValue,
  output logic [CNT_W-1:0] captureValue,
  output logic [gtm_pkg::GTM_FLAG_W-1:0] rawIrqStatus,
  output logic [gtm_pkg::GTM_FLAG_W-1:0] maskedIrqStatus,
  output logic irqRequest,
  output logic adcTrigger,
  output logic capturePwmPinOut
);
  import gtm_pkg::*;

  logic enQ, enD;
  logic [CNT_W-1:0] cntQ, cntD;
  logic [CNT_W-1:0] loadQ, loadD;
  logic [PS_W-1:0] psQ, psD;
  logic [CNT_W-1:0] matchQ, matchD;
  logic [CNT_W-1:0] capQ, capD;
  logic [GTM_FLAG_W-1:0] rawQ, rawD;
  logic [GTM_FLAG_W-1:0] misQ, misD;
  logic irqQ, irqD;
  logic adcQ, adcD;
  logic pwmQ, pwmD;
  logic pwmLvlQ, pwmLvlD;
  logic loadPendQ, loadPendD;
  gtm_op_e op;
  logic edgeHit;
  logic psTick;
  logic frozen;
  logic atZero;
  logic usePs;
  logic [GTM_FLAG_W-1:0] evt;

  // Decodes the operating mode from the mode bits.
  function automatic gtm_op_e decodeOp(input logic [2:0] cfg, input logic [1:0] mf,
                                       input logic cmr, input logic ams);
    if (cfg != GTM_CFG_16BIT) begin
      return GTM_OP_IDLE; // R01
    end
    if (ams) begin
      return (!cmr && mf == GTM_MODE_PERIODIC) ? GTM_OP_PWM : GTM_OP_IDLE; // R20
    end
    unique case (mf)
      GTM_MODE_ONESHOT: return GTM_OP_ONESHOT; // R23
      GTM_MODE_PERIODIC: return GTM_OP_PERIODIC; // R23
      GTM_MODE_CAPTURE: return cmr ? GTM_OP_ETIME : GTM_OP_ECOUNT; // R13 R17
      default: return GTM_OP_IDLE;
    endcase
  endfunction : decodeOp

  assign op = decodeOp(timerConfig, halfModeField, captureModeBit, alternateModeSelect);
  assign frozen = debugStallBit && debugHalt; // R10
  assign usePs = (op == GTM_OP_ONESHOT) || (op == GTM_OP_PERIODIC); // R03 R12
  assign atZero = (cntQ == GTM_ZERO);

  gtm_edge_detect u_edge (
    .clock(clock),
    .resetn(resetn),
    .pinIn(capturePwmPinIn),
    .edgeSel(edgeSelectField),
    .edgeHit(edgeHit)
  );

  gtm_prescaler #(.PS_W(PS_W)) u_ps (
    .clock(clock),
    .resetn(resetn),
    .run(enQ && !frozen && usePs),
    .reload(!enQ || (usePs && atZero) || prescaleWrite),
    .prescale(psD),
    .tick(psTick)
  );

  always_comb begin
    enD = enQ;
    cntD = cntQ;
    loadD = intervalLoadWrite ? intervalLoadData : loadQ;
    psD = prescaleWrite ? prescaleData : psQ;
    matchD = matchWrite ? matchData : matchQ;
    capD = capQ;
    pwmLvlD = pwmLvlQ;
    loadPendD = loadPendQ || (intervalLoadWrite && enQ);
    evt = '0;
    if (enQ && !frozen) begin
      if (loadPendQ && op != GTM_OP_ECOUNT) begin
        cntD = loadQ; // R09
        loadPendD = intervalLoadWrite;
      end else begin
        unique case (op)
          GTM_OP_ONESHOT, GTM_OP_PERIODIC: begin
            if (atZero) begin
              cntD = loadQ; // R04
              evt[GTM_FLAG_TIMEOUT] = 1'b1; // R06
              enD = (op == GTM_OP_PERIODIC); // R05
            end else if (psTick) begin
              cntD = cntQ - 1'b1; // R03
            end
          end
          GTM_OP_ECOUNT: begin
            if (cntQ == matchQ) begin
              cntD = loadQ; // R16
              enD = 1'b0; // R16
              evt[GTM_FLAG_CMATCH] = 1'b1; // R15
            end else if (edgeHit) begin
              cntD = cntQ - 1'b1; // R15
            end
          end
          GTM_OP_ETIME: begin
            cntD = atZero ? loadQ : cntQ - 1'b1; // R19
            if (edgeHit && edgeSelectField != GTM_EDGE_BOTH) begin
              capD = cntQ; // R18
              evt[GTM_FLAG_CEVENT] = 1'b1; // R18
            end
          end
          GTM_OP_PWM: begin
            cntD = atZero ? loadQ : cntQ - 1'b1; // R21
            if (cntQ == loadQ) begin
              pwmLvlD = 1'b1; // R22
            end else if (cntQ == matchQ) begin
              pwmLvlD = 1'b0; // R22
            end
          end
          default: begin
          end
        endcase
      end
    end else if (!enQ) begin
      cntD = loadD;
      loadPendD = 1'b0;
      pwmLvlD = 1'b0;
    end
    if (enableClear) begin
      enD = 1'b0;
    end else if (enableSet) begin
      enD = 1'b1;
    end
    // Hardware events win over a simultaneous software clear.
    rawD = (rawQ & ~irqClear) | evt; // R06 R24
    misD = rawD & irqMask; // R07 R24
    irqD = |misD; // R07
    adcD = evt[GTM_FLAG_TIMEOUT] && adcTriggerEnable; // R08
    pwmD = (op == GTM_OP_PWM && enQ) ? (pwmLvlD ^ pwmInvertBit) : pwmInvertBit; // R22
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      enQ <= 1'b0;
      cntQ <= GTM_LOAD_RST;
      loadQ <= GTM_LOAD_RST;
      psQ <= GTM_PRESCALE_RST;
      matchQ <= GTM_LOAD_RST;
      capQ <= GTM_LOAD_RST;
      rawQ <= '0;
      misQ <= '0;
      irqQ <= 1'b0;
      adcQ <= 1'b0;
      pwmQ <= 1'b0;
      pwmLvlQ <= 1'b0;
      loadPendQ <= 1'b0;
    end else begin
      enQ <= enD;
      cntQ <= cntD;
      loadQ <= loadD;
      psQ <= psD;
      matchQ <= matchD;
      capQ <= capD;
      rawQ <= rawD;
      misQ <= misD;
      irqQ <= irqD;
      adcQ <= adcD;
      pwmQ <= pwmD;
      pwmLvlQ <= pwmLvlD;
      loadPendQ <= loadPendD;
    end
  end

  assign halfEnableBit = enQ;
  assign countValue = cntQ;
  assign captureValue = capQ;
  assign rawIrqStatus = rawQ;
  assign maskedIrqStatus = misQ;
  assign irqRequest = irqQ;
  assign adcTrigger = adcQ;
  assign capturePwmPinOut = pwmQ;

  property p_oneshot_stops;
    @(posedge clock) disable iff (!resetn)
    (enQ && !frozen && !loadPendQ && op == GTM_OP_ONESHOT && atZero && !enableSet)
      |=> (!enQ && rawQ[GTM_FLAG_TIMEOUT] && cntQ == $past(loadQ));
  endproperty
  a_oneshot_stops: assert property (p_oneshot_stops) else $error("one-shot did not stop"); // R05

  property p_periodic_runs;
    @(posedge clock) disable iff (!resetn)
    (enQ && !frozen && !loadPendQ && op == GTM_OP_PERIODIC && atZero && !enableClear)
      |=> enQ;
  endproperty
  a_periodic_runs: assert property (p_periodic_runs) else $error("periodic stopped"); // R05

  property p_flag_sticky;
    @(posedge clock) disable iff (!resetn)
    (rawQ[GTM_FLAG_TIMEOUT] && !irqClear[GTM_FLAG_TIMEOUT]) |=> rawQ[GTM_FLAG_TIMEOUT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("time-out flag lost"); // R06

  property p_masked;
    @(posedge clock) disable iff (!resetn)
    ##1 (misQ == (rawQ & $past(irqMask))) && (irqQ == |misQ);
  endproperty
  a_masked: assert property (p_masked) else $error("masked status wrong"); // R07

  property p_adc;
    @(posedge clock) disable iff (!resetn)
    adcQ |-> ($past(adcTriggerEnable) && rawQ[GTM_FLAG_TIMEOUT]);
  endproperty
  a_adc: assert property (p_adc) else $error("adc trigger without cause"); // R08

  property p_stall;
    @(posedge clock) disable iff (!resetn)
    (enQ && frozen && !enableClear) |=> $stable(cntQ);
  endproperty
  a_stall: assert property (p_stall) else $error("counter moved while stalled"); // R10

  property p_ecount_step;
    @(posedge clock) disable iff (!resetn)
    (enQ && !frozen && op == GTM_OP_ECOUNT && cntQ != matchQ && !edgeHit)
      |=> $stable(cntQ);
  endproperty
  a_ecount_step: assert property (p_ecount_step) else $error("count moved without edge"); // R15

  property p_capture;
    @(posedge clock) disable iff (!resetn)
    (enQ && !frozen && !loadPendQ && op == GTM_OP_ETIME && edgeHit
      && edgeSelectField != GTM_EDGE_BOTH)
      |=> (capQ == $past(cntQ)) && rawQ[GTM_FLAG_CEVENT];
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed"); // R18

  property p_pwm_noflags;
    @(posedge clock) disable iff (!resetn)
    (op == GTM_OP_PWM && rawQ == '0 && $stable(op)) |=> rawQ == '0;
  endproperty
  a_pwm_noflags: assert property (p_pwm_noflags) else $error("flag in pwm mode"); // R21

  c_timeout: cover property (@(posedge clock) disable iff (!resetn)
    rawQ[GTM_FLAG_TIMEOUT]);
  c_match: cover property (@(posedge clock) disable iff (!resetn)
    rawQ[GTM_FLAG_CMATCH]);
  c_event: cover property (@(posedge clock) disable iff (!resetn)
    rawQ[GTM_FLAG_CEVENT]);
  c_pwm: cover property (@(posedge clock) disable iff (!resetn)
    op == GTM_OP_PWM && $rose(pwmQ));

endmodule : gtm_half_timer

// file: verif/gtm_ccp_source.sv
`timescale 1ns/1ns
module gtm_ccp_source #(
  parameter int HOLD = 3
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Request a burst of pin toggles.
  input wire logic start,
  input wire logic [4:0] edges,
  // Pin and status.
  output logic pinLevel,
  output logic busy
);
  int remain;
  int hold;
  // A hold of at least two clocks keeps every edge visible to the detector.
  always @(posedge clock) begin
    if (!resetn) begin
      pinLevel <= 1'b0;
      remain <= 0;
      hold <= 0;
    end else if (start) begin
      remain <= int'(edges);
      hold <= HOLD;
    end else if (remain > 0) begin
      if (hold == 0) begin
        pinLevel <= ~pinLevel;
        remain <= remain - 1;
        hold <= HOLD;
      end else begin
        hold <= hold - 1;
      end
    end
  end
  assign busy = (remain != 0);
endmodule : gtm_ccp_source

// file: verif/gtm_half_timer_tb.sv
`timescale 1ns/1ns
module gtm_half_timer_tb;
  import gtm_pkg::*;
  typedef struct {
    logic [1:0] mode; logic [15:0] load; logic [7:0] ps; logic ate; logic [2:0] mask;
    logic [15:0] gap; logic expEn;
  } gtm_row_s;
  logic clock, resetn, cmr, ams, ate, stall, inv, halt, enSet, enClr, ilW, psW, mW;
  logic [2:0] cfg, mask, clr, raw, mis;
  logic [1:0] modeF, edgeF;
  logic [15:0] ilD, mD, cnt, cap, prev;
  logic [7:0] psD;
  logic pinIn, en, irq, adc, pinOut, srcStart, srcBusy;
  logic [4:0] srcEdges;
  int fail_count, checked, n, hi;
  gtm_row_s rows [4] = '{
    '{GTM_MODE_ONESHOT, 16'h0003, 8'h00, 1'b1, 3'h1, 16'h0001, 1'b0},
    '{GTM_MODE_PERIODIC, 16'h0004, 8'h02, 1'b0, 3'h0, 16'h0003, 1'b1},
    '{GTM_MODE_ONESHOT, 16'h0003, 8'hFF, 1'b1, 3'h0, 16'h0100, 1'b0},
    '{GTM_MODE_PERIODIC, 16'h0010, 8'h01, 1'b1, 3'h1, 16'h0002, 1'b1}};
  logic [1:0] eSel [3] = '{GTM_EDGE_BOTH, GTM_EDGE_RISE, GTM_EDGE_FALL};
  logic [15:0] eMatch [3] = '{16'h0006, 16'h0008, 16'h0008};

  gtm_half_timer u_gtm_half_timer (.clock(clock), .resetn(resetn), .timerConfig(cfg),
    .halfModeField(modeF), .captureModeBit(cmr), .alternateModeSelect(ams),
    .edgeSelectField(edgeF), .adcTriggerEnable(ate), .debugStallBit(stall),
    .pwmInvertBit(inv), .debugHalt(halt), .enableSet(enSet), .enableClear(enClr),
    .intervalLoadData(ilD), .intervalLoadWrite(ilW), .prescaleData(psD),
    .prescaleWrite(psW), .matchData(mD), .matchWrite(mW), .irqMask(mask), .irqClear(clr),
    .capturePwmPinIn(pinIn), .halfEnableBit(en), .countValue(cnt), .captureValue(cap),
    .rawIrqStatus(raw), .maskedIrqStatus(mis), .irqRequest(irq), .adcTrigger(adc),
    .capturePwmPinOut(pinOut));
  gtm_ccp_source u_gtm_ccp_source (.clock(clock), .resetn(resetn), .start(srcStart),
    .edges(srcEdges), .pinLevel(pinIn), .busy(srcBusy));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task cyc(input int k);
    repeat (k) @(negedge clock);
  endtask : cyc

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse

  task waitRaw(input int b, input int lim);
    n = 0;
    while (raw[b] !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : waitRaw

  // Writes happen with the half disabled so the count simply follows the load.
  task setup(input logic [1:0] md, input logic c, input logic a, input logic [1:0] ed,
             input logic [15:0] ld, input logic [7:0] ps, input logic [15:0] mt);
    modeF = md; cmr = c; ams = a; edgeF = ed;
    ilD = ld; psD = ps; mD = mt; ilW = 1'b1; psW = 1'b1; mW = 1'b1; clr = 3'h7;
    cyc(1);
    ilW = 1'b0; psW = 1'b0; mW = 1'b0; clr = 3'h0;
    cyc(1);
  endtask : setup

  initial begin
    #40000;
    fail_count++;
    print_verdict();
  end

  initial begin
    {cmr, ams, ate, stall, inv, halt, enSet, enClr, ilW, psW, mW, srcStart} = '0;
    {mask, clr, modeF, edgeF, ilD, mD, psD, srcEdges} = '0;
    cfg = GTM_CFG_16BIT;
    resetn = 1'b0;
    cyc(12);
    resetn = 1'b1;
    cyc(1);
    chk("count", GTM_LOAD_RST, cnt);
    chk("capture", 16'hFFFF, cap);
    chk("enable", 16'h0, {15'h0, en});
    chk("flags", 16'h0, {13'h0, raw});
    chk("irq", 16'h0, {14'h0, irq, pinOut});
    foreach (rows[i]) begin
      setup(rows[i].mode, 1'b0, 1'b0, GTM_EDGE_RISE, rows[i].load, rows[i].ps, 16'hFFFF);
      ate = rows[i].ate;
      mask = rows[i].mask;
      pulse(enSet);
      for (int k = 0; k < 2; k++) begin
        prev = cnt;
        n = 0;
        while (cnt === prev && n < 600) begin
          cyc(1);
          n++;
        end
      end
      chk("gap", rows[i].gap, 16'(n));
      waitRaw(0, 2000);
      chk("timeout", 16'h1, {15'h0, raw[0]});
      chk("adc", {15'h0, rows[i].ate}, {15'h0, adc});
      chk("enable after", {15'h0, rows[i].expEn}, {15'h0, en});
      chk("masked", {14'h0, rows[i].mask[0], rows[i].mask[0]}, {14'h0, mis[0], irq});
      chk("reload", rows[i].load, cnt);
      cyc(2);
      chk("held", 16'h1, {15'h0, raw[0]});
      chk("adc pulse", 16'h0, {15'h0, adc});
      clr = 3'h6;
      cyc(1);
      chk("clear zero", 16'h1, {15'h0, raw[0]});
      clr = 3'h1;
      cyc(1);
      clr = 3'h0;
      chk("cleared", 16'h0, {14'h0, raw[0], mis[0]});
      pulse(enClr);
    end
    cfg = 3'h0;
    setup(GTM_MODE_ONESHOT, 1'b0, 1'b0, GTM_EDGE_RISE, 16'h0005, 8'h00, 16'hFFFF);
    pulse(enSet);
    cyc(20);
    chk("idle cfg", 16'h0, {13'h0, raw});
    cfg = GTM_CFG_16BIT;
    pulse(enClr);
    setup(GTM_MODE_PERIODIC, 1'b0, 1'b0, GTM_EDGE_RISE, 16'h0100, 8'h00, 16'hFFFF);
    pulse(enSet);
    halt = 1'b1;
    prev = cnt;
    cyc(4);
    chk("halt only", 16'h1, {15'h0, cnt !== prev});
    stall = 1'b1;
    cyc(2);
    prev = cnt;
    cyc(5);
    chk("stall", prev, cnt);
    halt = 1'b0;
    cyc(2);
    chk("resume", 16'h1, {15'h0, cnt !== prev});
    ilD = 16'h0050;
    ilW = 1'b1;
    cyc(1);
    ilW = 1'b0;
    cyc(1);
    chk("live load", 16'h1, {15'h0, cnt inside {[16'h004E:16'h0050]}});
    stall = 1'b0;
    pulse(enClr);
    for (int k = 0; k < 3; k++) begin
      setup(GTM_MODE_CAPTURE, 1'b0, 1'b0, eSel[k], 16'h000A, 8'h02, eMatch[k]);
      mask = 3'h2;
      pulse(enSet);
      srcEdges = 5'h06;
      pulse(srcStart);
      n = 0;
      while (srcBusy && n < 100) begin
        cyc(1);
        n++;
      end
      cyc(4);
      chk("edge match", 16'h3, {14'h0, raw[1], mis[1]});
      chk("edge stop", 16'h000A, cnt);
      chk("edge en", 16'h0, {15'h0, en});
    end
    setup(GTM_MODE_CAPTURE, 1'b1, 1'b0, GTM_EDGE_RISE, 16'h0040, 8'h05, 16'hFFFF);
    mask = 3'h4;
    pulse(enSet);
    srcEdges = 5'h02;
    pulse(srcStart);
    waitRaw(2, 50);
    chk("event", 16'h7, {13'h0, raw[2], mis[2], irq});
    chk("capture near", 16'h1, {15'h0, (cap > cnt) && (cap - cnt <= 16'h3)});
    prev = cap;
    cyc(10);
    chk("capture hold", prev, cap);
    n = 0;
    while (cnt !== 16'h0040 && n < 100) begin
      cyc(1);
      n++;
    end
    chk("free run", 16'h1, {15'h0, en && (cnt === 16'h0040)});
    pulse(enClr);
    setup(GTM_MODE_PERIODIC, 1'b0, 1'b1, GTM_EDGE_RISE, 16'h0008, 8'h03, 16'h0003);
    mask = 3'h7;
    for (int k = 0; k < 2; k++) begin
      inv = k[0];
      pulse(enSet);
      cyc(20);
      hi = 0;
      repeat (18) begin
        cyc(1);
        hi += int'(pinOut);
      end
      chk("pwm high", k ? 16'h0008 : 16'h000A, 16'(hi));
      chk("pwm flags", 16'h0, {12'h0, raw, irq});
      pulse(enClr);
    end
    // A reset in mid-run must drop a running half and its pending flags.
    setup(GTM_MODE_PERIODIC, 1'b0, 1'b0, GTM_EDGE_RISE, 16'h0004, 8'h00, 16'hFFFF);
    mask = 3'h1;
    pulse(enSet);
    waitRaw(0, 100);
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    chk("reset count", GTM_LOAD_RST, cnt);
    chk("reset state", 16'h0, {8'h0, en, raw, mis, irq});
    cyc(2);
    chk("reset hold", 16'h0, {14'h0, en, raw[0]});
    chk("reset load", GTM_LOAD_RST, cnt);
    print_verdict();
  end
endmodule : gtm_half_timer_tb
